// [core/exec_pkg.sv]
// shared constants for the rotate, subtract and sleep execution block
package exec_pkg;
   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // register byte addresses
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ACC = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_FILE_SEL = 8'h0C;
   localparam logic [7:0] REG_FILE_DATA = 8'h10;
   localparam logic [7:0] REG_WATCHDOG = 8'h14;
   localparam logic [7:0] REG_WAKE = 8'h18;

   // command word fields
   localparam int CMD_FADDR_POS = 0;
   localparam int CMD_DEST_POS = 7;
   localparam int CMD_OP_POS = 8;
   localparam int CMD_W = 11;

   // command opcodes
   localparam logic [2:0] OP_ROTATE_RIGHT = 3'h1;
   localparam logic [2:0] OP_ROTATE_LEFT = 3'h2;
   localparam logic [2:0] OP_SUB_ACC_FROM_FILE = 3'h3;
   localparam logic [2:0] OP_SLEEP = 3'h4;

   // status register bit positions
   localparam int ST_CARRY_POS = 0;
   localparam int ST_DIGIT_CARRY_POS = 1;
   localparam int ST_ZERO_POS = 2;
   localparam int ST_POWERDOWN_POS = 3;
   localparam int ST_TIMEOUT_POS = 4;
   localparam int ST_ASLEEP_POS = 5;

   // watchdog register field positions and wake bit
   localparam int WD_COUNT_POS = 0;
   localparam int WD_PRESCALER_POS = 8;
   localparam int WAKE_POS = 0;

   // reset values, and the watchdog clear value loaded by sleep
   localparam logic RST_TIMEOUT_FLAG = 1'b1;
   localparam logic RST_POWERDOWN_FLAG = 1'b1;
   localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : exec_pkg

// [core/rotate_subtract_sleep_exec.sv]
// execution core for rotate through carry, subtract accumulator from file, and sleep
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps

module rotate_subtract_sleep_exec (
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic ce,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [exec_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [exec_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [exec_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [exec_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // oscillator run request, low while asleep
   output logic osc_enable
);

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_got;
      logic w_got;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [10:0] cmd;
      logic [7:0] acc;
      logic carry;
      logic digit_carry;
      logic zero;
      logic powerdown_flag;
      logic timeout_flag;
      logic asleep;
      logic osc_enable;
      logic [6:0] file_sel;
      logic [127:0][7:0] file_mem;
      logic [7:0] watchdog_counter;
      logic [7:0] watchdog_prescaler;
   } state_t;

   localparam state_t RESET_STATE = '{
      timeout_flag: exec_pkg::RST_TIMEOUT_FLAG,
      powerdown_flag: exec_pkg::RST_POWERDOWN_FLAG,
      osc_enable: 1'b1,
      default: '0
   };

   state_t s;
   state_t next_s;

   // rotate through carry: returns {carry out, result}
   function automatic logic [8:0] rotate_carry(input logic [7:0] val, input logic cin, input logic left);
      if (left) begin
         rotate_carry = {val[7], val[6:0], cin};
      end else begin
         rotate_carry = {val[0], cin, val[7:1]};
      end
   endfunction : rotate_carry

   // two's complement subtract a - b: returns {borrow-free carry, digit carry, difference}
   function automatic logic [9:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, a} + {1'b0, ~b} + 9'h001;
      low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      sub_flags = {full[8], low[4], full[7:0]};
   endfunction : sub_flags

   // command fields of the buffered write, shared by execution and checks
   logic [2:0] cmd_op;
   logic cmd_dest;
   logic [6:0] cmd_faddr;
   logic [7:0] cmd_fval;
   logic cmd_write;
   logic exec_fire;
   assign cmd_op = s.wdata[exec_pkg::CMD_OP_POS +: 3];
   assign cmd_dest = s.wdata[exec_pkg::CMD_DEST_POS];
   assign cmd_faddr = s.wdata[exec_pkg::CMD_FADDR_POS +: 7];
   assign cmd_fval = s.file_mem[cmd_faddr];
   assign cmd_write = s.aw_got && s.w_got && !s.bvalid && s.waddr == exec_pkg::REG_CMD && s.wstrb[1:0] == 2'h3;
   assign exec_fire = cmd_write && !s.asleep && ce;

   // all next-state logic: bus slave, watchdog, and command execution
   always_comb begin
      logic [8:0] rot;
      logic [9:0] sub;
      logic [7:0] res;
      logic [31:0] rd;
      rot = '0;
      sub = '0;
      res = '0;
      rd = '0;
      next_s = s;

      // capture address and data separately; the master may send them in either order
      if (s.awready && awvalid) begin
         next_s.aw_got = 1'b1;
         next_s.waddr = awaddr;
      end
      if (s.wready && wvalid) begin
         next_s.w_got = 1'b1;
         next_s.wdata = wdata;
         next_s.wstrb = wstrb;
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end

      // watchdog keeps its own count, also in sleep since it has its own oscillator
      next_s.watchdog_prescaler = s.watchdog_prescaler + 8'h01;
      if (s.watchdog_prescaler == 8'hFF) begin
         next_s.watchdog_counter = s.watchdog_counter + 8'h01;
      end

      // perform a buffered write once both halves are here
      if (s.aw_got && s.w_got && !s.bvalid) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = exec_pkg::RESP_OKAY;
         case (s.waddr)
            exec_pkg::REG_CMD: begin
               // a half-written command word would execute garbage, so both low lanes are needed
               if (cmd_write) begin
                  next_s.cmd = s.wdata[exec_pkg::CMD_W-1:0];
               end
               if (cmd_write && !s.asleep) begin
                  unique case (cmd_op)
                     exec_pkg::OP_ROTATE_RIGHT, exec_pkg::OP_ROTATE_LEFT: begin
                        rot = rotate_carry(cmd_fval, s.carry, cmd_op == exec_pkg::OP_ROTATE_LEFT);
                        next_s.carry = rot[8];
                        if (cmd_dest) begin
                           next_s.file_mem[cmd_faddr] = rot[7:0];
                        end else begin
                           next_s.acc = rot[7:0];
                        end
                     end
                     exec_pkg::OP_SUB_ACC_FROM_FILE: begin
                        sub = sub_flags(cmd_fval, s.acc);
                        res = sub[7:0];
                        next_s.carry = sub[9];
                        next_s.digit_carry = sub[8];
                        next_s.zero = (res == 8'h00);
                        if (cmd_dest) begin
                           next_s.file_mem[cmd_faddr] = res;
                        end else begin
                           next_s.acc = res;
                        end
                     end
                     exec_pkg::OP_SLEEP: begin
                        next_s.powerdown_flag = 1'b0;
                        next_s.timeout_flag = 1'b1;
                        next_s.watchdog_counter = exec_pkg::WATCHDOG_CLEAR;
                        next_s.watchdog_prescaler = exec_pkg::WATCHDOG_CLEAR;
                        next_s.asleep = 1'b1;
                        next_s.osc_enable = 1'b0;
                     end
                     default: begin
                        // unknown opcodes do nothing
                     end
                  endcase
               end
            end
            exec_pkg::REG_ACC: begin
               if (s.wstrb[0]) begin
                  next_s.acc = s.wdata[7:0];
               end
            end
            exec_pkg::REG_STATUS: begin
               // power-down and time-out are read only, only sleep moves them
               if (s.wstrb[0]) begin
                  next_s.carry = s.wdata[exec_pkg::ST_CARRY_POS];
                  next_s.digit_carry = s.wdata[exec_pkg::ST_DIGIT_CARRY_POS];
                  next_s.zero = s.wdata[exec_pkg::ST_ZERO_POS];
               end
            end
            exec_pkg::REG_FILE_SEL: begin
               if (s.wstrb[0]) begin
                  next_s.file_sel = s.wdata[6:0];
               end
            end
            exec_pkg::REG_FILE_DATA: begin
               if (s.wstrb[0]) begin
                  next_s.file_mem[s.file_sel] = s.wdata[7:0];
               end
            end
            exec_pkg::REG_WATCHDOG: begin
               // read only; write is answered but ignored
            end
            exec_pkg::REG_WAKE: begin
               if (s.wstrb[0] && s.wdata[exec_pkg::WAKE_POS]) begin
                  next_s.asleep = 1'b0;
                  next_s.osc_enable = 1'b1;
               end
            end
            default: begin
               next_s.bresp = exec_pkg::RESP_SLVERR;
            end
         endcase
      end
      // one write in flight: no new halves until the response is taken
      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready = !next_s.w_got && !next_s.bvalid;

      // read channel, answered the cycle after the address is taken
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      if (s.arready && arvalid) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = exec_pkg::RESP_OKAY;
         case (araddr)
            exec_pkg::REG_CMD: rd[exec_pkg::CMD_W-1:0] = s.cmd;
            exec_pkg::REG_ACC: rd[7:0] = s.acc;
            exec_pkg::REG_STATUS: begin
               rd[exec_pkg::ST_CARRY_POS] = s.carry;
               rd[exec_pkg::ST_DIGIT_CARRY_POS] = s.digit_carry;
               rd[exec_pkg::ST_ZERO_POS] = s.zero;
               rd[exec_pkg::ST_POWERDOWN_POS] = s.powerdown_flag;
               rd[exec_pkg::ST_TIMEOUT_POS] = s.timeout_flag;
               rd[exec_pkg::ST_ASLEEP_POS] = s.asleep;
            end
            exec_pkg::REG_FILE_SEL: rd[6:0] = s.file_sel;
            exec_pkg::REG_FILE_DATA: rd[7:0] = s.file_mem[s.file_sel];
            exec_pkg::REG_WATCHDOG: begin
               rd[exec_pkg::WD_COUNT_POS +: 8] = s.watchdog_counter;
               rd[exec_pkg::WD_PRESCALER_POS +: 8] = s.watchdog_prescaler;
            end
            exec_pkg::REG_WAKE: rd[exec_pkg::WAKE_POS] = s.asleep;
            default: next_s.rresp = exec_pkg::RESP_SLVERR;
         endcase
         next_s.rdata = rd;
      end
      next_s.arready = !next_s.rvalid;
   end

   // single state register; low enable freezes everything
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s <= RESET_STATE;
      end else if (ce) begin
         s <= next_s;
      end
   end

   // outputs come straight from the state flops
   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rdata = s.rdata;
   assign rresp = s.rresp;
   assign osc_enable = s.osc_enable;
   // checker helpers: expected rotate result and carry out of the pending command
   logic [7:0] rot_expect;
   logic rot_cout;
   logic is_rot;
   assign is_rot = cmd_op == exec_pkg::OP_ROTATE_RIGHT || cmd_op == exec_pkg::OP_ROTATE_LEFT;
   assign rot_expect = (cmd_op == exec_pkg::OP_ROTATE_LEFT) ? {cmd_fval[6:0], s.carry} : {s.carry, cmd_fval[7:1]};
   assign rot_cout = (cmd_op == exec_pkg::OP_ROTATE_LEFT) ? cmd_fval[7] : cmd_fval[0];
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence sleep_issued;
      exec_fire && cmd_op == exec_pkg::OP_SLEEP;
   endsequence
   sequence halted_cmd;
      cmd_write && s.asleep && ce;
   endsequence
   AST_ROTATE_RIGHT_SHIFT: assert property (
      exec_fire && cmd_op == exec_pkg::OP_ROTATE_RIGHT && cmd_dest
      |=> s.file_mem[$past(cmd_faddr)] == {$past(s.carry), 7'($past(cmd_fval) >> 1)})
      else $error("rotate right result wrong");
   AST_ROT_DEST_ACC: assert property (
      exec_fire && is_rot && !cmd_dest
      |=> s.acc == $past(rot_expect) && s.file_mem[$past(cmd_faddr)] == $past(cmd_fval))
      else $error("rotate to accumulator wrong or file touched");
   AST_SUB_FLAGS: assert property (
      exec_fire && cmd_op == exec_pkg::OP_SUB_ACC_FROM_FILE
      |=> s.carry == ($past(s.acc) <= $past(cmd_fval))
          && s.digit_carry == ($past(s.acc[3:0]) <= $past(cmd_fval[3:0]))
          && s.zero == ($past(s.acc) == $past(cmd_fval)))
      else $error("subtract flags wrong");
   AST_SUB_DEST: assert property (
      exec_fire && cmd_op == exec_pkg::OP_SUB_ACC_FROM_FILE
      |=> (($past(cmd_dest) == 1'b0) ? s.acc : s.file_mem[$past(cmd_faddr)]) == 8'($past(cmd_fval) - $past(s.acc)))
      else $error("subtract result or destination wrong");
   AST_SLEEP_FLAGS: assert property (
      sleep_issued |=> !s.powerdown_flag && s.timeout_flag && $stable(s.carry) && $stable(s.digit_carry)
                       && $stable(s.zero))
      else $error("sleep status update wrong");
   AST_SLEEP_WATCHDOG: assert property (
      sleep_issued |=> s.watchdog_counter == exec_pkg::WATCHDOG_CLEAR && s.watchdog_prescaler == 8'h00)
      else $error("sleep did not clear watchdog");
   AST_SLEEP_HALT: assert property (
      sleep_issued |=> !osc_enable && s.asleep)
      else $error("oscillator not halted after sleep");
   AST_ASLEEP_NO_EXEC: assert property (
      halted_cmd |=> $stable(s.acc) && $stable(s.carry) && $stable(s.file_mem) && !osc_enable)
      else $error("command executed while asleep");
   AST_ROTATE_LEFT_SHIFT: assert property (
      exec_fire && cmd_op == exec_pkg::OP_ROTATE_LEFT && cmd_dest
      |=> s.file_mem[$past(cmd_faddr)] == {7'($past(cmd_fval)), $past(s.carry)})
      else $error("rotate left result wrong");
   AST_ROT_CARRY: assert property (
      exec_fire && is_rot |=> s.carry == $past(rot_cout))
      else $error("rotate carry out wrong");
endmodule : rotate_subtract_sleep_exec

// [testbench/rotate_subtract_sleep_exec_bench.sv]
// self-checking bench for the rotate, subtract and sleep execution block
`timescale 1ns/10ps
module rotate_subtract_sleep_exec_bench;
   logic mclk, rst_b, ce, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, osc_enable;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int error_cnt = 0;
   int comparisons = 0;
   int cycles = 0;

   rotate_subtract_sleep_exec uut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .osc_enable(osc_enable));

   // 50 ns period
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // hang guard, well above the several hundred cycles the scenarios need
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
      comparisons++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_resp

   // handshakes are judged at the falling edge, where nothing moves, and acted on at the next rise
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit pa;
      bit pw;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1;
      pw = 1;
      while (pa || pw) begin
         @(negedge mclk);
         if (pa && awready) pa = 0;
         if (pw && wready) pw = 0;
         @(posedge mclk);
         if (!pa) awvalid <= 1'b0;
         if (!pw) wvalid <= 1'b0;
      end
      do @(negedge mclk); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge mclk);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge mclk); while (arready !== 1'b1);
      @(posedge mclk);
      arvalid <= 1'b0;
      do @(negedge mclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge mclk);
      rready <= 1'b0;
   endtask : rd

   task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk_resp("bresp", exec_pkg::RESP_OKAY, r);
   endtask : wr_ok

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk_resp("rresp", exec_pkg::RESP_OKAY, r);
      chk(nm, e, d);
   endtask : rd_chk

   function automatic logic [31:0] st(input logic cy, dig, zr, pdn, tmo, sl);
      return (32'(cy) << exec_pkg::ST_CARRY_POS) | (32'(dig) << exec_pkg::ST_DIGIT_CARRY_POS)
         | (32'(zr) << exec_pkg::ST_ZERO_POS) | (32'(pdn) << exec_pkg::ST_POWERDOWN_POS)
         | (32'(tmo) << exec_pkg::ST_TIMEOUT_POS) | (32'(sl) << exec_pkg::ST_ASLEEP_POS);
   endfunction : st

   task automatic cmd(input logic [2:0] op, input logic d, input logic [6:0] f);
      wr_ok(exec_pkg::REG_CMD, {21'h0, op, d, f});
   endtask : cmd

   task automatic set_file(input logic [6:0] f, input logic [7:0] v);
      wr_ok(exec_pkg::REG_FILE_SEL, {25'h0, f});
      wr_ok(exec_pkg::REG_FILE_DATA, {24'h0, v});
   endtask : set_file

   task automatic file_chk(input logic [6:0] f, input logic [7:0] v);
      wr_ok(exec_pkg::REG_FILE_SEL, {25'h0, f});
      rd_chk(exec_pkg::REG_FILE_DATA, {24'h0, v}, "file");
   endtask : file_chk

   // old carry enters bit 7, old bit 0 leaves as carry; both destinations
   task automatic t_rotate_right();
      wr_ok(exec_pkg::REG_STATUS, 32'h1);
      set_file(7'h05, 8'hA5);
      cmd(exec_pkg::OP_ROTATE_RIGHT, 1'b0, 7'h05);
      rd_chk(exec_pkg::REG_ACC, 32'hD2, "acc");
      file_chk(7'h05, 8'hA5);
      rd_chk(exec_pkg::REG_STATUS, st(1, 0, 0, 1, 1, 0), "status");
      wr_ok(exec_pkg::REG_STATUS, 32'h0);
      cmd(exec_pkg::OP_ROTATE_RIGHT, 1'b1, 7'h05);
      file_chk(7'h05, 8'h52);
      rd_chk(exec_pkg::REG_ACC, 32'hD2, "acc");
      rd_chk(exec_pkg::REG_STATUS, st(1, 0, 0, 1, 1, 0), "status");
   endtask : t_rotate_right

   // mirror of the right rotate, the second pass feeding a set carry into bit 0
   task automatic t_rotate_left();
      wr_ok(exec_pkg::REG_STATUS, 32'h0);
      set_file(7'h7F, 8'hE6);
      cmd(exec_pkg::OP_ROTATE_LEFT, 1'b0, 7'h7F);
      rd_chk(exec_pkg::REG_ACC, 32'hCC, "acc");
      rd_chk(exec_pkg::REG_STATUS, st(1, 0, 0, 1, 1, 0), "status");
      cmd(exec_pkg::OP_ROTATE_LEFT, 1'b1, 7'h7F);
      file_chk(7'h7F, 8'hCD);
      rd_chk(exec_pkg::REG_ACC, 32'hCC, "acc");
   endtask : t_rotate_left

   // borrow, nibble borrow, zero and both destinations
   task automatic t_subtract();
      logic [7:0] fv[5] = '{8'h35, 8'h12, 8'h40, 8'h30, 8'h05};
      logic [7:0] av[5] = '{8'h12, 8'h35, 8'h40, 8'h05, 8'h10};
      logic [7:0] res[5] = '{8'h23, 8'hDD, 8'h00, 8'h2B, 8'hF5};
      logic [2:0] cdz[5] = '{3'b011, 3'b000, 3'b111, 3'b001, 3'b010};
      for (int i = 0; i < 5; i++) begin
         wr_ok(exec_pkg::REG_ACC, {24'h0, av[i]});
         set_file(7'(8'h20 + i), fv[i]);
         cmd(exec_pkg::OP_SUB_ACC_FROM_FILE, i[0], 7'(8'h20 + i));
         if (i[0]) begin
            file_chk(7'(8'h20 + i), res[i]);
            rd_chk(exec_pkg::REG_ACC, {24'h0, av[i]}, "acc");
         end else begin
            rd_chk(exec_pkg::REG_ACC, {24'h0, res[i]}, "acc");
            file_chk(7'(8'h20 + i), fv[i]);
         end
         rd_chk(exec_pkg::REG_STATUS, st(cdz[i][0], cdz[i][1], cdz[i][2], 1, 1, 0), "status");
      end
   endtask : t_subtract

   // flags, watchdog clear, halted oscillator, commands ignored until wake
   task automatic t_sleep();
      logic [31:0] d;
      logic [1:0] r;
      repeat (300) @(posedge mclk);
      rd(exec_pkg::REG_WATCHDOG, d, r);
      chk("wd_running", 32'h1, {31'h0, d[7:0] != 8'h00});
      wr_ok(exec_pkg::REG_STATUS, 32'h1);
      wr_ok(exec_pkg::REG_ACC, 32'h81);
      cmd(exec_pkg::OP_SLEEP, 1'b0, 7'h00);
      rd(exec_pkg::REG_WATCHDOG, d, r);
      chk("wd_count", 32'h0, {24'h0, d[7:0]});
      chk("wd_prescaler_fresh", 32'h1, {31'h0, d[15:8] < 8'h20});
      rd_chk(exec_pkg::REG_STATUS, st(1, 0, 0, 0, 1, 1), "status");
      chk("osc_enable", 32'h0, {31'h0, osc_enable});
      cmd(exec_pkg::OP_ROTATE_RIGHT, 1'b0, 7'h05);
      rd_chk(exec_pkg::REG_ACC, 32'h81, "acc");
      wr_ok(exec_pkg::REG_WAKE, 32'h1);
      rd_chk(exec_pkg::REG_STATUS, st(1, 0, 0, 0, 1, 0), "status");
      chk("osc_enable", 32'h1, {31'h0, osc_enable});
   endtask : t_sleep

   // unmapped address is refused on both paths with no data
   task automatic t_unmapped();
      logic [31:0] d;
      logic [1:0] r;
      rd(8'h40, d, r);
      chk_resp("rresp_unmapped", exec_pkg::RESP_SLVERR, r);
      chk("rdata_unmapped", 32'h0, d);
      wr(8'h40, 32'h5A, r);
      chk_resp("bresp_unmapped", exec_pkg::RESP_SLVERR, r);
   endtask : t_unmapped

   // low enable freezes all state: the free running watchdog only counts the four enabled edges
   task automatic t_clock_enable();
      logic [31:0] d;
      logic [31:0] e;
      logic [1:0] r;
      rd(exec_pkg::REG_WATCHDOG, d, r);
      @(posedge mclk);
      ce <= 1'b0;
      repeat (40) @(posedge mclk);
      ce <= 1'b1;
      rd(exec_pkg::REG_WATCHDOG, e, r);
      chk_resp("rresp_ce", exec_pkg::RESP_OKAY, r);
      chk("wd_ticks_ce", 32'h4, {16'h0, 16'({e[7:0], e[15:8]} - {d[7:0], d[15:8]})});
   endtask : t_clock_enable

   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'h0;
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      rd_chk(exec_pkg::REG_STATUS, st(0, 0, 0, 1, 1, 0), "status_reset");
      rd_chk(exec_pkg::REG_ACC, 32'h0, "acc_reset");
      chk("osc_enable_reset", 32'h1, {31'h0, osc_enable});
      t_rotate_right();
      t_rotate_left();
      t_subtract();
      t_sleep();
      t_unmapped();
      t_clock_enable();
      end_of_test();
   end
endmodule : rotate_subtract_sleep_exec_bench
